// ==== inc/spfid_pkg.sv ====
// Opcodes, field positions, reset values, timing and carrier types of the flash command block.
package spfid_pkg;
    localparam logic [7:0] READ_PARAM_TABLE_CMD      = 8'h5A;
    localparam logic [7:0] READ_UNIQUE_SERIAL_CMD    = 8'h4B;
    localparam logic [7:0] READ_STATUS_ONE_CMD       = 8'h05;
    localparam logic [7:0] READ_STATUS_TWO_CMD       = 8'h07;
    localparam logic [7:0] READ_CONFIG_ONE_CMD       = 8'h35;
    localparam logic [7:0] READ_CONFIG_TWO_CMD       = 8'h15;
    localparam logic [7:0] READ_CONFIG_THREE_CMD     = 8'h33;
    localparam logic [7:0] WRITE_REGS_CMD            = 8'h01;
    localparam logic [7:0] WRITE_ENABLE_CMD          = 8'h06;
    localparam logic [7:0] VOLATILE_WRITE_ENABLE_CMD = 8'h50;
    localparam logic [7:0] CLEAR_STATUS_CMD          = 8'h30;

    localparam int WIP_BIT    = 0;
    localparam int WEL_BIT    = 1;
    localparam int P_ERR_BIT  = 5;
    localparam int E_ERR_BIT  = 6;
    localparam int ADDR32_BIT = 0;
    localparam int QPI_BIT    = 3;
    localparam int LAT_MSB    = 3;
    localparam int LAT_LSB    = 0;

    localparam logic [7:0] STATUS_ONE_RST   = 8'h00;
    localparam logic [7:0] CONFIG_ONE_RST   = 8'h00;
    localparam logic [7:0] CONFIG_TWO_RST   = 8'h00;
    localparam logic [7:0] CONFIG_THREE_RST = 8'h08;

    localparam logic [5:0] OPCODE_BITS     = 6'h08;
    localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
    localparam logic [5:0] ADDR_BITS_LONG  = 6'h20;
    localparam logic [5:0] UID_DUMMY_CLKS  = 6'h20;
    localparam logic [5:0] POST_BITS_MAX   = 6'h3F;
    localparam int         UID_BYTES       = 8;
    localparam int         PT_DEPTH        = 16;
    localparam int         PT_AW           = 4;
    localparam int         CLK_PERIOD_NS   = 20;
    localparam int         WRR_TIME_US_DEF = 1000;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_WDATA,
        ST_SKIP
    } spfid_state_t;

    typedef struct packed {
        logic        done;
        logic [7:0]  opcode;
        logic [5:0]  post_bits;
        logic [31:0] wdata;
    } spfid_frame_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
    } spfid_regs_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
    } spfid_view_t;

    localparam spfid_regs_t REGS_RST = {STATUS_ONE_RST, CONFIG_ONE_RST,
                                        CONFIG_TWO_RST, CONFIG_THREE_RST};
endpackage

// ==== logic/spfid_top.sv ====
// Serial flash parameter-table, unique-ID and register command interpreter.
// Functional notes
// RULE1: Param-table read is 5Ah, 24/32-bit address per setting, then latency dummies.
// RULE2: Param-table dummy count comes from config three bits 3:0.
// RULE3: Read bytes leave on falling clock edges, most significant bit first.
// RULE4: Param-table read starts at given address and continues sequentially.
// RULE5: Host keeps single-bit param-table clock at or below 108 MHz.
// RULE6: Latency ships as 8 cycles; host may change address length and latency.
// RULE7: Quad mode takes opcode on four lines and returns four bits per clock.
// RULE8: Opcode 4Bh reads a fixed 64-bit per-device unique number.
// RULE9: Unique-ID read waits 32 clocks; data lines ignored meanwhile.
// RULE10: Eight unique-ID bytes follow in order; later bytes are undefined.
// RULE11: Raising chip select ends a read and stops output drive.
// RULE12: 05h and 07h return status one and two, even while busy.
// RULE13: Status byte repeats while clocked, refreshed every eight clocks.
// RULE14: 35h, 15h, 33h return config one, two, three, repeating every byte.
// RULE15: In quad mode host uses 65h for status two and config reads.
// RULE16: Register write 01h needs prior write-enable or volatile-write-enable.
// RULE17: Non-volatile write updates stored copies then volatile; volatile write only volatile.
// RULE18: Failed write sets an error flag and stays busy until clear-status.
// RULE19: Host writes zero to all reserved register bits.
// RULE20: Write length of 8/16/24/32 bits picks registers; other lengths cancel.
// RULE21: Timed write starts at chip select rise; busy flag high; latch clears after.
// RULE22: Resets are ignored while a register write runs.
// RULE23: Clear-status 30h clears busy, latch and both errors, even when busy.
// RULE24: Volatile-write-enable leaves the latch alone and redirects the next write.
// RULE25: Busy is status one bit 0, latch bit 1; write-enable sets latch.
// RULE26: Single-bit opcode and address are sampled on rising edges, MSB first.
`timescale 1ns/100ps
`default_nettype none
module spfid_top
    import spfid_pkg::*;
#(
    parameter int          WRR_TIME_US = WRR_TIME_US_DEF,
    parameter logic [63:0] UNIQUE_ID   = 64'h0123_4567_89AB_CDEF  // Arbitrary value.
) (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic [3:0] i_io,
    output logic      [3:0] o_io,
    output logic      [3:0] o_io_oe_n,
    input  wire logic [1:0] i_nv_fault,
    input  wire logic       i_reset_req,
    output logic            o_wip,
    output logic            o_wel,
    output logic            o_quad_mode
);
    localparam int WRR_CYCLES = (WRR_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam logic [7:0] PARAM_ROM [PT_DEPTH] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hFF,
        8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF};

    logic         rst_s1_r;
    logic         rst_n_r;
    logic         cs_s1_r;
    logic         cs_s2_r;
    logic         cs_s3_r;
    spfid_regs_t  regs_r;
    spfid_regs_t  nv_r;
    spfid_regs_t  pend_r;
    spfid_view_t  view_r;
    spfid_view_t  view_s1_r;
    spfid_view_t  view_s2_r;
    spfid_frame_t frame_r;
    spfid_state_t st_r;
    logic [5:0]   cnt_r;
    logic [31:0]  shin_r;
    logic [31:0]  addr_r;
    logic [7:0]   osh_r;
    logic [3:0]   ocnt_r;
    logic [15:0]  oidx_r;
    logic [3:0]   io_r;
    logic [3:0]   oe_n_r;
    logic         wip_r;
    logic         busy_r;
    logic [23:0]  timer_r;
    logic         p_err_r;
    logic         e_err_r;
    logic         wel_r;
    logic         vol_r;

    // Mode bits change at a volatile write's frame end, at write completion or on reset, so they can change mid-frame; the link side reads them directly.
    logic        quad_peripheral_mode;
    logic        addr32;
    logic [5:0]  step;
    logic [5:0]  addr_len;
    logic [5:0]  dummy_len;
    logic [31:0] shin_nxt;
    logic [6:0]  post_sum;
    logic [7:0]  src_byte;
    assign quad_peripheral_mode       = regs_r.c2[QPI_BIT];
    assign addr32    = regs_r.c2[ADDR32_BIT];
    assign step      = quad_peripheral_mode ? 6'h04 : 6'h01;
    assign addr_len  = addr32 ? ADDR_BITS_LONG : ADDR_BITS_SHORT;
    assign dummy_len = (frame_r.opcode == READ_UNIQUE_SERIAL_CMD) ? UID_DUMMY_CLKS :
                       {2'b00, regs_r.c3[LAT_MSB:LAT_LSB]};
    assign shin_nxt  = quad_peripheral_mode ? {shin_r[27:0], i_io} : {shin_r[30:0], i_io[0]};
    assign post_sum  = {1'b0, frame_r.post_bits} + {1'b0, step};

    function automatic spfid_state_t next_state(input logic [7:0] op);
        case (op)
            READ_PARAM_TABLE_CMD:   next_state = ST_ADDR;
            READ_UNIQUE_SERIAL_CMD: next_state = ST_DUMMY;
            READ_STATUS_ONE_CMD,
            READ_STATUS_TWO_CMD,
            READ_CONFIG_ONE_CMD,
            READ_CONFIG_TWO_CMD,
            READ_CONFIG_THREE_CMD:  next_state = ST_DATA;
            WRITE_REGS_CMD:         next_state = ST_WDATA;
            default:                next_state = ST_SKIP;
        endcase
    endfunction

    function automatic logic [7:0] fetch_byte(input logic [7:0] op, input logic [31:0] a,
                                              input logic [15:0] idx, input spfid_view_t v);
        logic [31:0] pa;
        pa = a + {16'h0000, idx};
        case (op)
            READ_PARAM_TABLE_CMD:
                fetch_byte = (pa < PT_DEPTH) ? PARAM_ROM[pa[PT_AW-1:0]] : 8'hFF;  // [RULE4]
            READ_UNIQUE_SERIAL_CMD:
                fetch_byte = (idx < UID_BYTES) ? UNIQUE_ID[63 - 8 * idx[2:0] -: 8] : 8'h00;  // [RULE8] [RULE10]
            READ_STATUS_ONE_CMD:   fetch_byte = v.s1;  // [RULE12]
            READ_STATUS_TWO_CMD:   fetch_byte = v.s2;  // [RULE12]
            READ_CONFIG_ONE_CMD:   fetch_byte = v.c1;  // [RULE14]
            READ_CONFIG_TWO_CMD:   fetch_byte = v.c2;  // [RULE14]
            READ_CONFIG_THREE_CMD: fetch_byte = v.c3;  // [RULE14]
            default:               fetch_byte = 8'h00;
        endcase
    endfunction

    function automatic spfid_regs_t merge(input spfid_regs_t b, input logic [31:0] d,
                                          input logic [5:0] bits);
        spfid_regs_t m;
        m = b;
        unique case (bits)
            6'h08: m.s1 = d[7:0];
            6'h10: {m.s1, m.c1} = d[15:0];
            6'h18: {m.s1, m.c1, m.c2} = d[23:0];
            6'h20: {m.s1, m.c1, m.c2, m.c3} = d;
        endcase
        merge = m;  // [RULE20]
    endfunction

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // Frame end reaches the system clock through a synchroniser; the frame record is static by then.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    logic frame_end;
    logic single;
    logic len_ok;
    logic write_enable_cmd_evt;
    logic volatile_write_enable_cmd_evt;
    logic clear_status_cmd_evt;
    logic wrr_evt;
    logic nv_start;
    logic nv_done;
    logic nv_done_ok;
    logic reset_ok;
    assign frame_end  = cs_s2_r & ~cs_s3_r;
    assign single     = frame_end & frame_r.done & (frame_r.post_bits == 6'h00);
    assign len_ok     = (frame_r.post_bits == 6'h08) | (frame_r.post_bits == 6'h10) |
                        (frame_r.post_bits == 6'h18) | (frame_r.post_bits == 6'h20);  // [RULE20]
    assign write_enable_cmd_evt   = single & (frame_r.opcode == WRITE_ENABLE_CMD) & ~wip_r;
    assign volatile_write_enable_cmd_evt  = single & (frame_r.opcode == VOLATILE_WRITE_ENABLE_CMD) & ~wip_r;
    assign clear_status_cmd_evt   = single & (frame_r.opcode == CLEAR_STATUS_CMD);  // [RULE23]
    assign wrr_evt    = frame_end & frame_r.done & (frame_r.opcode == WRITE_REGS_CMD) &
                        len_ok & (wel_r | vol_r) & ~wip_r;  // [RULE16] [RULE21]
    assign nv_start   = wrr_evt & ~vol_r;
    assign nv_done    = busy_r & (timer_r == 24'h000000);
    assign nv_done_ok = nv_done & (i_nv_fault == 2'b00);
    assign reset_ok   = i_reset_req & ~wip_r;  // [RULE22]

    // Error sets are placed after the clear so a coincident failure survives clear-status.
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wip_r   <= 1'b0;
            busy_r  <= 1'b0;
            timer_r <= 24'h000000;
            p_err_r <= 1'b0;
            e_err_r <= 1'b0;
        end else begin
            if (clear_status_cmd_evt) begin
                wip_r   <= 1'b0;  // [RULE23]
                busy_r  <= 1'b0;
                p_err_r <= 1'b0;
                e_err_r <= 1'b0;
            end
            if (nv_start) begin
                wip_r   <= 1'b1;  // [RULE21]
                busy_r  <= 1'b1;
                timer_r <= 24'(WRR_CYCLES - 1);
            end else if (busy_r) begin
                if (timer_r != 24'h000000) begin
                    timer_r <= timer_r - 24'h000001;
                end else begin
                    busy_r <= 1'b0;
                    if (i_nv_fault == 2'b00) begin
                        wip_r <= 1'b0;  // [RULE21]
                    end else begin
                        wip_r   <= 1'b1;  // [RULE18]
                        p_err_r <= p_err_r | i_nv_fault[1];
                        e_err_r <= e_err_r | i_nv_fault[0];
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wel_r <= 1'b0;
            vol_r <= 1'b0;
        end else begin
            if (clear_status_cmd_evt || nv_done_ok || reset_ok) begin
                wel_r <= 1'b0;  // [RULE21] [RULE23]
            end
            if (write_enable_cmd_evt) begin
                wel_r <= 1'b1;  // [RULE25]
            end
            if (volatile_write_enable_cmd_evt) begin
                vol_r <= 1'b1;  // [RULE24]
            end else if (write_enable_cmd_evt || wrr_evt || reset_ok) begin
                vol_r <= 1'b0;  // [RULE16]
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            regs_r <= REGS_RST;  // [RULE6]
            nv_r   <= REGS_RST;
            pend_r <= REGS_RST;
        end else begin
            if (wrr_evt && vol_r) begin
                regs_r <= merge(regs_r, frame_r.wdata, frame_r.post_bits);  // [RULE17]
            end else if (nv_done_ok) begin
                regs_r <= pend_r;  // [RULE17]
            end else if (reset_ok) begin
                regs_r <= nv_r;
            end
            if (nv_done_ok) begin
                nv_r <= pend_r;
            end
            if (nv_start) begin
                pend_r <= merge(nv_r, frame_r.wdata, frame_r.post_bits);
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            view_r <= '0;
        end else begin
            view_r <= {regs_r.s1[7:2], wel_r, wip_r, 1'b0, e_err_r, p_err_r, 5'b00000,
                       regs_r.c1, regs_r.c2, regs_r.c3};  // [RULE25]
        end
    end

    // Status words cross to the link clock; a byte may mix old and new bits only mid-update.
    always_ff @(posedge i_sck or negedge rst_n_r) begin
        if (!rst_n_r) begin
            view_s1_r <= '0;
            view_s2_r <= '0;
        end else begin
            view_s1_r <= view_r;
            view_s2_r <= view_s1_r;
        end
    end

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            st_r   <= ST_OPCODE;
            cnt_r  <= 6'h00;
            shin_r <= 32'h00000000;
            addr_r <= 32'h00000000;
        end else begin
            shin_r <= shin_nxt;  // [RULE26] [RULE7]
            unique case (st_r)
                ST_OPCODE: begin
                    if (cnt_r + step == OPCODE_BITS) begin
                        cnt_r <= 6'h00;
                        st_r  <= next_state(shin_nxt[7:0]);
                    end else begin
                        cnt_r <= cnt_r + step;
                    end
                end
                ST_ADDR: begin
                    if (cnt_r + step == addr_len) begin
                        cnt_r  <= 6'h00;
                        addr_r <= addr32 ? shin_nxt : {8'h00, shin_nxt[23:0]};  // [RULE1]
                        st_r   <= (dummy_len == 6'h00) ? ST_DATA : ST_DUMMY;
                    end else begin
                        cnt_r <= cnt_r + step;
                    end
                end
                ST_DUMMY: begin
                    if (cnt_r + 6'h01 == dummy_len) begin
                        cnt_r <= 6'h00;
                        st_r  <= ST_DATA;  // [RULE2] [RULE9]
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                ST_DATA, ST_WDATA, ST_SKIP: begin
                    cnt_r <= cnt_r;
                end
            endcase
        end
    end

    always_ff @(posedge i_sck or negedge rst_n_r) begin
        if (!rst_n_r) begin
            frame_r <= '0;
        end else if (st_r == ST_OPCODE) begin
            if (cnt_r == 6'h00) begin
                frame_r.done <= 1'b0;
            end
            if (cnt_r + step == OPCODE_BITS) begin
                frame_r.done      <= 1'b1;
                frame_r.opcode    <= shin_nxt[7:0];
                frame_r.post_bits <= 6'h00;
                frame_r.wdata     <= 32'h00000000;
            end
        end else begin
            frame_r.post_bits <= post_sum[6] ? POST_BITS_MAX : post_sum[5:0];  // [RULE20]
            if (st_r == ST_WDATA) begin
                frame_r.wdata <= quad_peripheral_mode ? {frame_r.wdata[27:0], i_io} : {frame_r.wdata[30:0], i_io[0]};
            end
        end
    end

    assign src_byte = (ocnt_r == 4'h0) ? fetch_byte(frame_r.opcode, addr_r, oidx_r, view_s2_r) :
                      osh_r;

    // Chip select high releases the lines at once, without waiting for a clock.
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            io_r   <= 4'h0;
            oe_n_r <= 4'hF;  // [RULE11]
            osh_r  <= 8'h00;
            ocnt_r <= 4'h0;
            oidx_r <= 16'h0000;
        end else if (st_r == ST_DATA) begin
            if (ocnt_r == 4'h0) begin
                oidx_r <= oidx_r + 16'h0001;  // [RULE13]
            end
            if (quad_peripheral_mode) begin
                io_r   <= src_byte[7:4];  // [RULE7]
                osh_r  <= {src_byte[3:0], 4'h0};
                oe_n_r <= 4'h0;
                ocnt_r <= (ocnt_r == 4'h0) ? 4'h4 : ocnt_r - 4'h4;
            end else begin
                io_r   <= {2'b00, src_byte[7], 1'b0};  // [RULE3]
                osh_r  <= {src_byte[6:0], 1'b0};
                oe_n_r <= 4'hD;
                ocnt_r <= (ocnt_r == 4'h0) ? 4'h7 : ocnt_r - 4'h1;
            end
        end
    end

    assign o_io        = io_r;
    assign o_io_oe_n   = oe_n_r;
    assign o_wip       = wip_r;
    assign o_wel       = wel_r;
    assign o_quad_mode = regs_r.c2[QPI_BIT];

    a_wip_while_busy: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        busy_r |-> wip_r) else $error("busy flag low during register write");  // [RULE21]
    a_done_clears: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        nv_done_ok && !nv_start |=> !wip_r && !wel_r && (regs_r == nv_r))
        else $error("write completion did not clear flags or copy values");  // [RULE17]
    a_fault_hangs: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        nv_done && (i_nv_fault != 2'b00) |=> (wip_r && (p_err_r || e_err_r)) [*2])
        else $error("failed write did not hang busy with error");  // [RULE18]
    a_clear_status_cmd_clears: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        clear_status_cmd_evt && !nv_done |=> !wip_r && !wel_r && !p_err_r && !e_err_r)
        else $error("clear-status left a flag set");  // [RULE23]
    a_volatile_write_enable_cmd_no_latch: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        volatile_write_enable_cmd_evt && !wel_r |=> !wel_r && vol_r)
        else $error("volatile enable touched the latch");  // [RULE24]
    a_write_enable_cmd_sets: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        write_enable_cmd_evt |=> wel_r && !vol_r) else $error("write enable did not set latch");  // [RULE25]
    a_reset_ignored: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        i_reset_req && wip_r && !nv_done |=> $stable(regs_r) && wip_r)
        else $error("reset disturbed a running write");  // [RULE22]
    a_bad_len_cancel: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        frame_end && (frame_r.opcode == WRITE_REGS_CMD) && !len_ok && !busy_r && !i_reset_req
        |=> $stable(regs_r) && !busy_r) else $error("odd-length write executed");  // [RULE20]
    a_read_drives: assert property (@(posedge i_sck) disable iff (i_cs_n)
        ($past(st_r) == ST_DATA) && (st_r == ST_DATA) |-> !o_io_oe_n[1])
        else $error("data phase without output drive");  // [RULE3]
    a_uid_latency: assert property (@(posedge i_sck) disable iff (i_cs_n)
        $rose(st_r == ST_DATA) && (frame_r.opcode == READ_UNIQUE_SERIAL_CMD)
        |-> ($past(st_r) == ST_DUMMY) && ($past(cnt_r) == UID_DUMMY_CLKS - 6'h01))
        else $error("unique-ID latency not 32 clocks");  // [RULE9]

    c_nv_write: cover property (@(posedge i_clk) disable iff (!rst_n_r) nv_done_ok);
    c_vol_write: cover property (@(posedge i_clk) disable iff (!rst_n_r) wrr_evt && vol_r);
    c_fault_clear: cover property (@(posedge i_clk) disable iff (!rst_n_r) clear_status_cmd_evt && p_err_r);
    c_read_out: cover property (@(posedge i_sck) disable iff (i_cs_n) st_r == ST_DATA);
endmodule
`default_nettype wire

// ==== bench/spfid_host.sv ====
// Host controller model that drives chip select, the link clock and the data line.
`timescale 1ns/100ps
`default_nettype none
module spfid_host (
    output logic       o_sck,
    output logic       o_cs_n,
    output logic [3:0] o_io,
    input  wire logic  i_so,
    input  wire logic  i_so_oe_n
);
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_io   = 4'h0;
    end
    // Single-bit frames only, at 15.6 MHz. Register reads in quad mode would use 65h.
    // Sends nt bits MSB first, then nd ignored clocks, then gathers nr bits.
    task automatic xfer(input logic [39:0] tx, input int nt, input int nd, input int nr,
                        output logic [63:0] rx);
        rx = '0;
        o_cs_n = 1'b0;
        for (int i = 0; i < nt + nd + nr; i++) begin
            // Unused clocks toggle the line so a stale level is never mistaken for data.
            o_io = (i < nt) ? {3'h0, tx[39-i]} : ~o_io;
            #32 o_sck = 1'b1;
            if (i >= nt + nd)
                rx = {rx[62:0], i_so_oe_n ? ~rx[0] : i_so};
            #32 o_sck = 1'b0;
        end
        #32 o_cs_n = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// ==== bench/spfid_top_tb.sv ====
// Self-checking bench for the flash command block.
`timescale 1ns/100ps
`default_nettype none
module spfid_top_tb;
    import spfid_pkg::*;
    localparam logic [63:0] UID = 64'hC3A5_0F1E_9B7D_2468; // Arbitrary value.
    logic        i_clk       = 1'b0;
    logic        i_nrst      = 1'b0;
    logic        i_reset_req = 1'b0;
    logic [1:0]  i_nv_fault  = 2'h0;
    logic        sck, cs_n, write_in_progress, write_enable_latch, qm;
    logic [3:0]  h_io, d_io, oe_n;
    logic [63:0] rx;
    int          fail_count  = 0;
    int          cmp_count   = 0;
    logic [7:0]  ops [5] = '{READ_STATUS_ONE_CMD, READ_STATUS_TWO_CMD, READ_CONFIG_ONE_CMD,
                             READ_CONFIG_TWO_CMD, READ_CONFIG_THREE_CMD};
    logic [7:0]  rv [5]  = '{STATUS_ONE_RST, 8'h00, CONFIG_ONE_RST, CONFIG_TWO_RST,
                             CONFIG_THREE_RST};
    wire  [3:0]  io_w    = (oe_n & h_io) | (~oe_n & d_io);
    spfid_top #(.WRR_TIME_US(2), .UNIQUE_ID(UID)) u_spfid_top (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_sck(sck), .i_cs_n(cs_n), .i_io(io_w), .o_io(d_io), .o_io_oe_n(oe_n),
        .i_nv_fault(i_nv_fault), .i_reset_req(i_reset_req), .o_wip(write_in_progress), .o_wel(write_enable_latch),
        .o_quad_mode(qm));
    spfid_host u_spfid_host (.o_sck(sck), .o_cs_n(cs_n), .o_io(h_io), .i_so(io_w[1]),
        .i_so_oe_n(oe_n[1]));
    always #10 i_clk = ~i_clk;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmd(input logic [39:0] tx, input int nt, input int nd = 0, input int nr = 0);
        u_spfid_host.xfer(tx, nt, nd, nr, rx);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Two bytes prove the value repeats; drive must be gone once chip select is high.
    task automatic rdreg(input logic [7:0] op, input logic [7:0] exp);
        cmd({op, 32'h0}, 8, 0, 16);
        chk(rx, {48'h0, exp, exp});
        chk(oe_n, 4'hF);
    endtask
    initial begin
        #1ms;
        fail_count++;
        end_sim();
    end
    initial begin
        ticks(8);
        i_nrst <= 1'b1;
        ticks(4);
        chk({write_in_progress, write_enable_latch, qm, oe_n}, {3'h0, 4'hF});
        for (int k = 0; k < 5; k++)
            rdreg(ops[k], rv[k]);
        cmd({READ_PARAM_TABLE_CMD, 24'h00000A, 8'h0}, 32, 8, 32);
        chk(rx, 64'h0110_3000);
        cmd({READ_UNIQUE_SERIAL_CMD, 32'h0}, 8, 32, 64);
        chk(rx, UID);
        cmd({READ_UNIQUE_SERIAL_CMD, 32'h0}, 8, 32, 12);
        chk({rx[11:0], oe_n}, {UID[63:52], 4'hF});
        cmd({WRITE_REGS_CMD, 32'h0000_0005}, 40);
        chk(write_in_progress, 1'b0);
        rdreg(READ_CONFIG_THREE_CMD, 8'h08);
        cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
        rdreg(READ_STATUS_ONE_CMD, 8'h02);
        cmd({WRITE_REGS_CMD, 32'h0000_0007}, 40);
        chk(write_in_progress, 1'b1);
        i_reset_req <= 1'b1;
        ticks(3);
        i_reset_req <= 1'b0;
        rdreg(READ_STATUS_ONE_CMD, 8'h03);
        for (int n = 0; n < 300 && write_in_progress !== 1'b0; n++)
            @(posedge i_clk);
        chk({write_in_progress, write_enable_latch}, 2'b00);
        rdreg(READ_CONFIG_THREE_CMD, 8'h07);
        cmd({WRITE_ENABLE_CMD, 32'h0}, 8);
        ticks(1);
        i_nv_fault <= 2'b10;
        cmd({WRITE_REGS_CMD, 32'h0}, 16);
        ticks(150);
        chk(write_in_progress, 1'b1);
        rdreg(READ_STATUS_TWO_CMD, 8'h20);
        ticks(1);
        i_nv_fault <= 2'b00;
        cmd({CLEAR_STATUS_CMD, 32'h0}, 8);
        chk({write_in_progress, write_enable_latch}, 2'b00);
        rdreg(READ_STATUS_TWO_CMD, 8'h00);
        cmd({VOLATILE_WRITE_ENABLE_CMD, 32'h0}, 8);
        chk(write_enable_latch, 1'b0);
        cmd({WRITE_REGS_CMD, 32'h0000_0104}, 40);
        chk(write_in_progress, 1'b0);
        rdreg(READ_CONFIG_TWO_CMD, 8'h01);
        cmd({READ_PARAM_TABLE_CMD, 32'h0000_0001}, 40, 4, 16);
        chk(rx, 64'h4644);
        cmd({VOLATILE_WRITE_ENABLE_CMD, 32'h0}, 8);
        cmd({WRITE_REGS_CMD, 32'h0}, 20);
        rdreg(READ_CONFIG_THREE_CMD, 8'h04);
        i_reset_req <= 1'b1;
        ticks(3);
        i_reset_req <= 1'b0;
        ticks(4);
        rdreg(READ_CONFIG_THREE_CMD, 8'h07);
        cmd({VOLATILE_WRITE_ENABLE_CMD, 32'h0}, 8);
        cmd({WRITE_REGS_CMD, 32'h0000_0800}, 32);
        chk(qm, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
